/* core/dspm_pkg.sv */
// shared constants, types and the CRC helper for the dual-channel speed/position monitor
package dspm_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned NUM_CH = 2;
  // measurement timing
  localparam int unsigned SLOT_MS = 8;
  localparam int unsigned SLOT_CYCLES = SLOT_MS * 1000 * CLK_MHZ;
  localparam int unsigned GATE_MS = 256;
  localparam int unsigned GATE_SLOTS = GATE_MS / SLOT_MS;
  localparam int unsigned FILTER_MAX_MS = 64;
  localparam int unsigned FILTER_SLOTS = FILTER_MAX_MS / SLOT_MS;
  localparam int unsigned MAX_RATE_HZ = 500;
  localparam int unsigned SLOT_W = 12;
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned PERIOD_W = 26;
  localparam logic [25:0] PERIOD_MAX = 26'h3FFFFFF;
  // line and message supervision
  localparam int unsigned SHORT_US = 2;
  localparam int unsigned SHORT_CYCLES = SHORT_US * CLK_MHZ;
  localparam int unsigned STUCK_MS = 10;
  localparam int unsigned STUCK_CYCLES = STUCK_MS * 1000 * CLK_MHZ;
  localparam int unsigned MSG_TIMEOUT_MS = 10;
  localparam int unsigned MSG_TIMEOUT_CYCLES = MSG_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] MSG_LEN = 8'h04;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  // fault flag positions
  localparam int unsigned FAULT_W = 7;
  localparam int unsigned F_POS = 0;
  localparam int unsigned F_SPD = 1;
  localparam int unsigned F_SHORT = 2;
  localparam int unsigned F_OPEN = 3;
  localparam int unsigned F_STUCK = 4;
  localparam int unsigned F_CRC = 5;
  localparam int unsigned F_FRAME = 6;

  typedef enum logic [1:0] {
    HEAD_CAMERA = 2'b01,
    HEAD_RAIL = 2'b10
  } dspm_head_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] len;
    logic [31:0] pos;
    logic [31:0] crc;
  } dspm_msg_type;

  // reflected CRC-32 over the position word, least significant bit first
  function automatic logic [31:0] crc32_word(input logic [31:0] d);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 32; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return ~c;
  endfunction
endpackage

/* core/dspm_channel.sv */
// per-channel speed, period and acceleration measurement with mean-value filter
`timescale 1ns/1ns
`default_nettype none
module dspm_channel #(
  parameter int unsigned SLOT_CYCLES = dspm_pkg::SLOT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // steps seen by this channel
  input wire logic stepValid,
  input wire logic [7:0] stepAdd,
  // filter window in 8 ms units
  input wire logic [3:0] filterSel,
  // measurements
  output logic [15:0] speed,
  output logic [25:0] period,
  output logic signed [16:0] accel
);
  logic [31:0] slotTimer;
  logic [11:0] curCount;
  logic [11:0] slotMem [dspm_pkg::FILTER_SLOTS];
  logic [4:0] gateSlot;
  logic [15:0] gateSpeed;
  logic [25:0] sinceStep;
  logic slotEnd;
  logic gateEnd;
  logic [12:0] sumCount;
  logic [11:0] next_count;
  logic [3:0] win;
  logic [14:0] winSum;
  logic [17:0] scaled;
  logic [17:0] quotient;
  logic [15:0] next_speed;
  logic stepSeen;

  assign slotEnd = (slotTimer == 32'(SLOT_CYCLES - 1));
  assign gateEnd = slotEnd && (gateSlot == 5'(dspm_pkg::GATE_SLOTS - 1));
  assign stepSeen = stepValid && (stepAdd != 8'h00);
  assign sumCount = {1'b0, curCount} + 13'(stepValid ? stepAdd : 8'h00);
  assign next_count = sumCount[12] ? 12'hFFF : sumCount[11:0];
  // window of 0 still uses the newest slot; each extra 8 ms adds that much latency
  assign win = (filterSel == 4'h0) ? 4'h1 : ((filterSel > 4'h8) ? 4'h8 : filterSel);

  always_comb begin
    winSum = 15'h0000;
    for (int i = 0; i < dspm_pkg::FILTER_SLOTS; i++) begin
      if (4'(i) < win) begin
        winSum = winSum + 15'(slotMem[i]);
      end
    end
  end

  // speed unit is steps per 64 ms regardless of window, so channels stay comparable
  assign scaled = {winSum, 3'b000};
  assign quotient = scaled / 18'(win);
  assign next_speed = (quotient > 18'h0FFFF) ? 16'hFFFF : quotient[15:0];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      slotTimer <= 32'h00000000;
      curCount <= 12'h000;
      for (int i = 0; i < dspm_pkg::FILTER_SLOTS; i++) begin
        slotMem[i] <= 12'h000;
      end
      gateSlot <= 5'h00;
      gateSpeed <= 16'h0000;
      speed <= 16'h0000;
      accel <= 17'sh00000;
    end else begin
      slotTimer <= slotEnd ? 32'h00000000 : slotTimer + 32'h00000001;
      // frequency measurement: steps counted per slot gate
      if (slotEnd) begin
        slotMem[0] <= next_count;
        for (int i = 1; i < dspm_pkg::FILTER_SLOTS; i++) begin
          slotMem[i] <= slotMem[i-1];
        end
        curCount <= 12'h000;
        gateSlot <= gateSlot + 5'h01;
      end else begin
        curCount <= next_count;
      end
      speed <= next_speed;
      // acceleration from speed change across one 256 ms gate
      if (gateEnd) begin
        accel <= $signed({1'b0, speed}) - $signed({1'b0, gateSpeed});
        gateSpeed <= speed;
      end
    end
  end

  // time measurement: cycles between steps, growing when steps stop
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sinceStep <= 26'h0000000;
      period <= dspm_pkg::PERIOD_MAX;
    end else if (stepSeen) begin
      period <= sinceStep;
      sinceStep <= 26'h0000000;
    end else begin
      if (sinceStep != dspm_pkg::PERIOD_MAX) begin
        sinceStep <= sinceStep + 26'h0000001;
      end
      if (sinceStep > period) begin
        period <= sinceStep;
      end
    end
  end

  chk_slot_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    slotEnd |=> (curCount == 12'h000) && (slotTimer == 32'h00000000))
    else $error("slot gate did not restart");
  chk_period_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stepSeen |=> (period == $past(sinceStep)) && (sinceStep == 26'h0000000))
    else $error("step period not captured");
  chk_accel_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$stable(accel) |-> $past(gateEnd))
    else $error("acceleration changed outside gate end");
  chk_filter_unit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (filterSel == 4'h0) |=> (speed == 16'({$past(slotMem[0]), 3'b000})))
    else $error("unfiltered speed not scaled slot count");
endmodule
`default_nettype wire

/* core/dspm_monitor.sv */
// dual-channel position and speed cross-check with read head line supervision
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - continuously compare channel A against channel B
// - position gap above threshold is a failure
// - speed gap above threshold is a failure
// - speed by step counting plus period timing
// - acceleration from speed over 256 ms gate
// - mean filter window 0 to 64 ms
// - filter window adds to response time
// - equal complementary lines mean short circuit
// - missing messages mean interrupted line
// - line without edges means stuck level
// - camera head position needs valid CRC32
// - code rail message address and length checked
module dspm_monitor #(
  parameter int unsigned SLOT_CYCLES = dspm_pkg::SLOT_CYCLES,
  parameter int unsigned STUCK_CYCLES = dspm_pkg::STUCK_CYCLES,
  parameter int unsigned MSG_TIMEOUT_CYCLES = dspm_pkg::MSG_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // read heads, index 0 is channel A
  input wire dspm_pkg::dspm_msg_type msgIn [dspm_pkg::NUM_CH],
  input wire logic [1:0] linePair [dspm_pkg::NUM_CH],
  // configuration
  input wire dspm_pkg::dspm_head_type headType [dspm_pkg::NUM_CH],
  input wire logic [7:0] railAddr [dspm_pkg::NUM_CH],
  input wire logic [31:0] posThresh,
  input wire logic [15:0] speedThresh,
  input wire logic [3:0] filterSel,
  // measurements
  output logic [31:0] position [dspm_pkg::NUM_CH],
  output logic [15:0] speed [dspm_pkg::NUM_CH],
  output logic [25:0] period [dspm_pkg::NUM_CH],
  output logic signed [16:0] accel [dspm_pkg::NUM_CH],
  // fault state
  output logic [dspm_pkg::FAULT_W-1:0] faultFlags,
  output logic safeReq
);
  logic [dspm_pkg::FAULT_W-1:0] chFault [dspm_pkg::NUM_CH];
  logic havePos [dspm_pkg::NUM_CH];
  logic [31:0] posGap;
  logic [31:0] posGapAbs;
  logic [16:0] spdGap;
  logic [15:0] spdGapAbs;
  logic posTrip;
  logic spdTrip;
  logic [dspm_pkg::FAULT_W-1:0] next_fault;

  for (genvar ch = 0; ch < dspm_pkg::NUM_CH; ch++) begin : g_ch
    logic [1:0] linePrev;
    logic [15:0] eqCnt;
    logic [31:0] idleCnt [2];
    logic [31:0] msgAge;
    logic lineEq;
    logic shortHit;
    logic stuckHit;
    logic openHit;
    logic crcBad;
    logic frameBad;
    logic accept;
    logic [31:0] delta;
    logic [31:0] absDelta;
    logic [7:0] stepAdd;

    assign lineEq = (linePair[ch][0] == linePair[ch][1]);
    // a brief equal phase is tolerated so edge skew between the pair is no fault
    assign shortHit = lineEq && (eqCnt == 16'(dspm_pkg::SHORT_CYCLES - 1));
    assign stuckHit = (idleCnt[0] == 32'(STUCK_CYCLES - 1))
                   || (idleCnt[1] == 32'(STUCK_CYCLES - 1));
    assign openHit = (msgAge == 32'(MSG_TIMEOUT_CYCLES - 1));
    assign crcBad = msgIn[ch].valid && (headType[ch] == dspm_pkg::HEAD_CAMERA)
                 && (dspm_pkg::crc32_word(msgIn[ch].pos) != msgIn[ch].crc);
    // an unknown head type refuses every message rather than trusting it
    assign frameBad = msgIn[ch].valid
                   && (((headType[ch] == dspm_pkg::HEAD_RAIL)
                        && ((msgIn[ch].addr != railAddr[ch])
                            || (msgIn[ch].len != dspm_pkg::MSG_LEN)))
                       || ((headType[ch] != dspm_pkg::HEAD_RAIL)
                           && (headType[ch] != dspm_pkg::HEAD_CAMERA)));
    assign accept = msgIn[ch].valid && !crcBad && !frameBad;
    assign delta = msgIn[ch].pos - position[ch];
    assign absDelta = delta[31] ? (32'h00000000 - delta) : delta;
    assign stepAdd = !havePos[ch] ? 8'h00 : ((absDelta > 32'h000000FF) ? 8'hFF : absDelta[7:0]);

    assign chFault[ch][dspm_pkg::F_POS] = 1'b0;
    assign chFault[ch][dspm_pkg::F_SPD] = 1'b0;
    assign chFault[ch][dspm_pkg::F_SHORT] = shortHit;
    assign chFault[ch][dspm_pkg::F_OPEN] = openHit;
    assign chFault[ch][dspm_pkg::F_STUCK] = stuckHit;
    assign chFault[ch][dspm_pkg::F_CRC] = crcBad;
    assign chFault[ch][dspm_pkg::F_FRAME] = frameBad;

    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        // start from the present level so reset leaves no false edge behind
        linePrev <= linePair[ch];
        eqCnt <= 16'h0000;
        idleCnt[0] <= 32'h00000000;
        idleCnt[1] <= 32'h00000000;
      end else begin
        linePrev <= linePair[ch];
        if (!lineEq) begin
          eqCnt <= 16'h0000;
        end else if (!shortHit) begin
          eqCnt <= eqCnt + 16'h0001;
        end
        for (int k = 0; k < 2; k++) begin
          if (linePair[ch][k] != linePrev[k]) begin
            idleCnt[k] <= 32'h00000000;
          end else if (idleCnt[k] != 32'(STUCK_CYCLES - 1)) begin
            idleCnt[k] <= idleCnt[k] + 32'h00000001;
          end
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        msgAge <= 32'h00000000;
        havePos[ch] <= 1'b0;
        position[ch] <= 32'h00000000;
      end else if (accept) begin
        msgAge <= 32'h00000000;
        havePos[ch] <= 1'b1;
        position[ch] <= msgIn[ch].pos;
      end else if (!openHit) begin
        msgAge <= msgAge + 32'h00000001;
      end
    end

    // speed reaches the compare only through the filter, so a trip lags by the window
    dspm_channel #(
      .SLOT_CYCLES(SLOT_CYCLES)
    ) u_meas (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .stepValid(accept),
      .stepAdd(stepAdd),
      .filterSel(filterSel),
      .speed(speed[ch]),
      .period(period[ch]),
      .accel(accel[ch])
    );

    chk_crc_reject: assert property (@(posedge sys_clk) disable iff (!rst_b)
      crcBad |=> faultFlags[dspm_pkg::F_CRC] && $stable(position[ch]))
      else $error("bad CRC accepted");
    chk_frame_reject: assert property (@(posedge sys_clk) disable iff (!rst_b)
      frameBad |=> faultFlags[dspm_pkg::F_FRAME] && $stable(position[ch]))
      else $error("bad frame accepted");
    chk_short_detect: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (lineEq && (eqCnt == 16'(dspm_pkg::SHORT_CYCLES - 2)))
        ##1 lineEq |=> faultFlags[dspm_pkg::F_SHORT])
      else $error("line short not flagged");
    chk_stuck_detect: assert property (@(posedge sys_clk) disable iff (!rst_b)
      stuckHit |=> faultFlags[dspm_pkg::F_STUCK] && safeReq)
      else $error("stuck line not flagged");
    chk_open_detect: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (msgAge == 32'(MSG_TIMEOUT_CYCLES - 2)) && !accept |=> ##1 faultFlags[dspm_pkg::F_OPEN])
      else $error("message loss not flagged");
  end

  // channels are compared on every clock, not sampled
  assign posGap = position[0] - position[1];
  assign posGapAbs = posGap[31] ? (32'h00000000 - posGap) : posGap;
  assign posTrip = havePos[0] && havePos[1] && (posGapAbs > posThresh);
  assign spdGap = {1'b0, speed[0]} - {1'b0, speed[1]};
  assign spdGapAbs = spdGap[16] ? 16'(17'h00000 - spdGap) : spdGap[15:0];
  assign spdTrip = (spdGapAbs > speedThresh);

  always_comb begin
    next_fault = chFault[0] | chFault[1];
    next_fault[dspm_pkg::F_POS] = posTrip;
    next_fault[dspm_pkg::F_SPD] = spdTrip;
  end

  // only reset clears: a safety fault must not self-heal when the cause vanishes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      faultFlags <= '0;
      safeReq <= 1'b0;
    end else begin
      faultFlags <= faultFlags | next_fault;
      safeReq <= |(faultFlags | next_fault);
    end
  end

  chk_pos_trip: assert property (@(posedge sys_clk) disable iff (!rst_b)
    posTrip |=> faultFlags[dspm_pkg::F_POS] && safeReq)
    else $error("position gap not flagged");
  chk_speed_trip: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (speed[0] > speed[1]) && ((speed[0] - speed[1]) > speedThresh)
      |=> faultFlags[dspm_pkg::F_SPD])
    else $error("speed gap not flagged");
  chk_compare_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !faultFlags[dspm_pkg::F_POS] && !faultFlags[dspm_pkg::F_SPD]
      && (position[0] == position[1]) && (speed[0] == speed[1])
      |=> !faultFlags[dspm_pkg::F_POS] && !faultFlags[dspm_pkg::F_SPD])
    else $error("fault without cause");
  chk_fault_latch: assert property (@(posedge sys_clk) disable iff (!rst_b)
    safeReq |=> safeReq && ($past(faultFlags) & ~faultFlags) == '0)
    else $error("fault indication dropped before reset");
  chk_speed_rev_trip: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (speed[1] > speed[0]) && ((speed[1] - speed[0]) > speedThresh)
      |=> faultFlags[dspm_pkg::F_SPD])
    else $error("reverse speed gap not flagged");
  chk_pos_gap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    havePos[0] && havePos[1]
      && (((position[0] >= position[1]) ? (position[0] - position[1])
           : (position[1] - position[0])) > posThresh)
      |=> faultFlags[dspm_pkg::F_POS] && safeReq)
    else $error("position gap beyond threshold not flagged");
  chk_safe_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
    safeReq == (faultFlags != '0))
    else $error("safe-state request disagrees with fault flags");
endmodule
`default_nettype wire

/* tb/dspm_head_model.sv */
// read head model: message strobe and complementary line pair of one channel
`timescale 1ns/1ns
`default_nettype none
module dspm_head_model (
  // clock and expected rail address
  input wire logic sys_clk,
  input wire logic [7:0] addr,
  // head outputs
  output var dspm_pkg::dspm_msg_type msg,
  output var logic [1:0] linePair
);
  // mode 0 live complementary, 1 shorted pair, 2 frozen
  logic [1:0] lineMode = 2'h0;
  logic [3:0] tick = 4'h0;
  initial msg = '0;
  initial linePair = 2'b10;
  function automatic logic [31:0] headCrc(input logic [31:0] d);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 32; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    return ~c;
  endfunction
  // err: 0 good, 1 bad check word, 2 bad address, 3 bad length
  task automatic send(input logic [31:0] pos, input logic [1:0] err);
    dspm_pkg::dspm_msg_type idle;
    @(negedge sys_clk);
    msg.valid = 1'h1;
    msg.pos = pos;
    msg.crc = headCrc(pos) ^ {31'h0, err == 2'h1};
    msg.addr = addr ^ {7'h0, err == 2'h2};
    msg.len = (err == 2'h3) ? 8'h05 : 8'h04;
    @(negedge sys_clk);
    // a released strobe never repeats the last fields
    idle = ~msg;
    idle.valid = 1'h0;
    msg = idle;
  endtask
  always @(negedge sys_clk) begin
    tick <= tick + 4'h1;
    if (lineMode == 2'h0) begin
      linePair <= {~tick[3], tick[3]};
    end else if (lineMode == 2'h1) begin
      linePair <= {tick[3], tick[3]};
    end
  end
endmodule
`default_nettype wire

/* tb/dspm_monitor_test.sv */
// self-checking bench for the dual-channel monitor
`timescale 1ns/1ns
`default_nettype none
module dspm_monitor_test;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  dspm_pkg::dspm_msg_type msgIn [2];
  logic [1:0] linePair [2];
  dspm_pkg::dspm_head_type headType [2];
  logic [7:0] railAddr [2];
  logic [31:0] posThresh = 32'h00000010;
  logic [15:0] speedThresh = 16'hFFFF;
  logic [3:0] filterSel = 4'h0;
  logic [31:0] position [2];
  logic [15:0] speed [2];
  logic [25:0] period [2];
  logic signed [16:0] accel [2];
  logic [6:0] faultFlags;
  logic safeReq;
  int miscompares = 0;
  int samples_checked = 0;
  int seedDummy;
  int n;
  logic [31:0] base;
  logic [31:0] gap;
  dspm_pkg::dspm_head_type kinds [3];

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  dspm_head_model u_hd0 (.sys_clk(sys_clk), .addr(railAddr[0]), .msg(msgIn[0]),
    .linePair(linePair[0]));
  dspm_head_model u_hd1 (.sys_clk(sys_clk), .addr(railAddr[1]), .msg(msgIn[1]),
    .linePair(linePair[1]));
  // short slots and timeouts keep the run brief; timeouts stay above the short window
  dspm_monitor #(.SLOT_CYCLES(16), .STUCK_CYCLES(800), .MSG_TIMEOUT_CYCLES(800)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .msgIn(msgIn), .linePair(linePair),
    .headType(headType), .railAddr(railAddr), .posThresh(posThresh),
    .speedThresh(speedThresh), .filterSel(filterSel), .position(position), .speed(speed),
    .period(period), .accel(accel), .faultFlags(faultFlags), .safeReq(safeReq));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic restart(input dspm_pkg::dspm_head_type ta, input dspm_pkg::dspm_head_type tb,
      input logic [1:0] ma, input logic [1:0] mb);
    @(negedge sys_clk);
    rst_b = 1'h0;
    headType[0] = ta;
    headType[1] = tb;
    u_hd0.lineMode = ma;
    u_hd1.lineMode = mb;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'h1;
  endtask
  // bounded wait for any fault; running out is a mismatch
  task automatic waitFlags(input int bound);
    n = 0;
    while (faultFlags === 7'h00 && n < bound) begin
      @(negedge sys_clk);
      n++;
    end
    if (faultFlags === 7'h00) begin
      miscompares++;
      test_done();
    end
  endtask
  function automatic logic [31:0] state();
    return {24'h0, safeReq, faultFlags};
  endfunction
  function automatic logic [31:0] expFault(input int bitPos);
    return 32'h80 | (32'h1 << bitPos);
  endfunction
  function automatic logic [31:0] expErr(input dspm_pkg::dspm_head_type t, input logic [1:0] e);
    if (t == dspm_pkg::HEAD_CAMERA) begin
      return (e == 2'h1) ? expFault(dspm_pkg::F_CRC) : 32'h0;
    end
    if (t == dspm_pkg::HEAD_RAIL) begin
      return (e >= 2'h2) ? expFault(dspm_pkg::F_FRAME) : 32'h0;
    end
    return expFault(dspm_pkg::F_FRAME);
  endfunction
  // steps in one slot scaled to a 64 ms unit, spread over the filter window
  function automatic logic [31:0] expSpeed(input int steps, input int f);
    return (steps * 8) / ((f == 0) ? 1 : f);
  endfunction

  initial begin
    railAddr[0] = 8'h5A;
    railAddr[1] = 8'hC3;
    kinds[0] = dspm_pkg::HEAD_CAMERA;
    kinds[1] = dspm_pkg::HEAD_RAIL;
    kinds[2] = dspm_pkg::dspm_head_type'(2'b00);
    headType[0] = kinds[0];
    headType[1] = kinds[1];
    seedDummy = $urandom(32'h2ae9);
    restart(kinds[0], kinds[1], 2'h0, 2'h0);
    check("period", 32'(period[0]), 32'h03FFFFFF);
    check("state", state(), 32'h0);
    // channels agree within the cut-off, the boundary gap included
    for (int i = 0; i < 12; i++) begin
      base = 32'h1000 + ($urandom % 32'h100);
      gap = (i == 0) ? 32'h10 : ($urandom % 32'h11);
      fork
        u_hd0.send(base, 2'h0);
        u_hd1.send(base + gap, 2'h0);
      join
      check("posA", position[0], base);
      check("posB", position[1], base + gap);
      check("state", state(), 32'h0);
    end
    u_hd1.send(base + 32'h11, 2'h0);
    waitFlags(4);
    check("posGap", state(), expFault(dspm_pkg::F_POS));
    fork
      u_hd0.send(base, 2'h0);
      u_hd1.send(base, 2'h0);
    join
    check("latched", state(), expFault(dspm_pkg::F_POS));
    // every head kind against every corruption
    for (int k = 0; k < 3; k++) begin
      for (int e = 1; e < 4; e++) begin
        restart(kinds[k], kinds[k], 2'h0, 2'h0);
        base = $urandom % 32'h10000;
        u_hd0.send(base, 2'(e));
        repeat (2) @(negedge sys_clk);
        check("errState", state(), expErr(kinds[k], 2'(e)));
        check("errPos", position[0], (expErr(kinds[k], 2'(e)) != 0) ? 32'h0 : base);
      end
    end
    // speed gap with and without the mean filter
    for (int f = 0; f <= 4; f += 4) begin
      filterSel = 4'(f);
      speedThresh = 16'h0064;
      posThresh = 32'h000000FF;
      restart(kinds[0], kinds[1], 2'h0, 2'h0);
      fork
        u_hd0.send(32'h3E8, 2'h0);
        u_hd1.send(32'h3E8, 2'h0);
      join
      u_hd0.send(32'h3FC, 2'h0);
      n = 0;
      while (speed[0] === 16'h0 && n < 40) begin
        @(negedge sys_clk);
        n++;
      end
      if (speed[0] === 16'h0) begin
        miscompares++;
        test_done();
      end
      check("speedA", 32'(speed[0]), expSpeed(20, f));
      repeat (2) @(negedge sys_clk);
      check("spdGap", 32'(faultFlags[1]), 32'(expSpeed(20, f) > 100));
    end
    // steady motion, one step per message, eight per slot; window code above 8 clamps to 8
    filterSel = 4'hF;
    restart(kinds[0], kinds[1], 2'h0, 2'h0);
    for (int i = 0; i < 300; i++) begin
      fork
        u_hd0.send(32'(i), 2'h0);
        u_hd1.send(32'(i), 2'h0);
      join
    end
    check("speedB", 32'(speed[1]), expSpeed(8, 0));
    check("accelA", 32'(accel[0]), expSpeed(8, 0));
    check("accelB", 32'(accel[1]), expSpeed(8, 0));
    check("periodA", 32'(period[0]), 32'h1);
    check("steady", state(), 32'h0);
    restart(kinds[0], kinds[1], 2'h1, 2'h1);
    waitFlags(600);
    check("short", state(), expFault(dspm_pkg::F_SHORT));
    check("shortTime", 32'(n >= 498 && n <= 502), 32'h1);
    restart(kinds[0], kinds[1], 2'h0, 2'h0);
    waitFlags(900);
    check("open", state(), expFault(dspm_pkg::F_OPEN));
    restart(kinds[0], kinds[1], 2'h0, 2'h2);
    for (int i = 0; i < 12 && faultFlags === 7'h00; i++) begin
      fork
        u_hd0.send(32'h40, 2'h0);
        u_hd1.send(32'h40, 2'h0);
      join
      repeat (100) @(negedge sys_clk);
    end
    check("stuck", state(), expFault(dspm_pkg::F_STUCK));
    test_done();
  end
endmodule
`default_nettype wire
